//--- logic/swe_pkg.sv
// swe_pkg: constants, register map and wake mapping for the suspend/wake
// logic; assumes 32-bit classic wishbone with word-aligned byte addresses.
package swe_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned NSRC = 12;
  // register byte offsets
  localparam logic [7:0] OFF_PMC = 8'h00;
  localparam logic [7:0] OFF_WCS1 = 8'h04;
  localparam logic [7:0] OFF_PIN = 8'h08;
  localparam logic [7:0] OFF_ISR = 8'h0c;
  localparam logic [7:0] OFF_SRC = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // power_mgmt_ctrl fields
  localparam int unsigned PMC_WAKE_PENDING_STATUS_LSB = 0;
  localparam int unsigned PMC_LAN_EN = 4;
  localparam int unsigned PMC_PHY_EN = 5;
  localparam int unsigned PMC_SUSPN_REL = 6;
  localparam int unsigned PMC_MODE_LSB = 8;
  localparam logic [1:0] MODE_S01 = 2'h0;
  localparam logic [1:0] MODE_S2 = 2'h2;
  localparam logic [1:0] MODE_S3 = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_S2;
  // wake_ctrl_status_one fields; status bits sit at STAT_LSB upward
  localparam int unsigned W1_DA_EN = 0;
  localparam int unsigned W1_BROADCAST_WAKE_ENABLE = 1;
  localparam int unsigned W1_FILT_EN = 2;
  localparam int unsigned W1_KEEP = 3;
  localparam int unsigned W1_EERX_EN = 4;
  localparam int unsigned W1_EETX_EN = 5;
  localparam int unsigned W1_STAT_LSB = 16;
  // pin register fields
  localparam int unsigned PIN_POL_LSB = 8;
  localparam int unsigned PIN_FUNC_LSB = 16;
  // wake source indices
  localparam int unsigned S_RES = 0;
  localparam int unsigned S_VBUS = 1;
  localparam int unsigned S_MAC_LSB = 2;
  localparam int unsigned S_GOOD = 6;
  localparam int unsigned S_LINK = 10;
  localparam int unsigned S_GPIO = 11;
  localparam int unsigned SRC_GPIO_LSB = 8;
  localparam logic [11:0] LAN_MASK = 12'h3fc;

  typedef enum logic [6:0] {
    SWE_CTX_NONE = 7'h01,
    SWE_CTX_S01 = 7'h02,
    SWE_CTX_S2 = 7'h04,
    SWE_CTX_S3 = 7'h08,
    SWE_CTX_UNPOW = 7'h10,
    SWE_CTX_PME = 7'h20,
    SWE_CTX_DETACH = 7'h40
  } swe_ctx_e;

  // RQ1 RQ2 RQ3 RQ4 sources allowed per context
  function automatic logic [11:0] allowed_mask(input swe_ctx_e ctx);
    case (ctx)
      SWE_CTX_S01: allowed_mask = 12'hfbd;
      SWE_CTX_S2: allowed_mask = 12'h801;
      SWE_CTX_S3: allowed_mask = 12'hffd;
      SWE_CTX_UNPOW: allowed_mask = 12'h002;
      SWE_CTX_PME: allowed_mask = 12'hc3c;
      SWE_CTX_DETACH: allowed_mask = 12'hc00;
      default: allowed_mask = 12'h000;
    endcase
  endfunction
endpackage

//--- logic/swe_wake_if.sv
// swe_wake_if: carries pin wake and source mapping signals inside the block;
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface swe_wake_if;
  logic [7:0] pin_level;
  logic [7:0] pin_en;
  logic [7:0] pin_pol;
  logic [7:0] pin_func;
  logic [7:0] pin_event;
  swe_pkg::swe_ctx_e ctx;
  logic [11:0] src_status;
  logic [11:0] src_enable;
  logic [11:0] allowed;
  logic [11:0] src_hit;
  modport pin_end (input pin_level, pin_en, pin_pol, pin_func,
    output pin_event);
  modport map_end (input ctx, src_status, src_enable,
    output allowed, src_hit);
  modport core (output pin_level, pin_en, pin_pol, pin_func, ctx,
    src_status, src_enable, input pin_event, allowed, src_hit);
endinterface

//--- logic/swe_pin_wake.sv
// swe_pin_wake: turns armed, enabled pins into one-cycle wake events;
// assumes pin levels are synchronous to clk.
`timescale 1ns/1ps
module swe_pin_wake
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side
  swe_wake_if.pin_end wif
);
  logic [7:0] active;
  logic [7:0] active_q;

  // polarity bit high means the pin wakes when high
  assign active = ~(wif.pin_level ^ wif.pin_pol) & wif.pin_en
    & wif.pin_func;

  always_ff @(posedge clk)
  begin
    if (rst)
      active_q <= 8'h00;
    else
      active_q <= active;
  end

  assign wif.pin_event = active & ~active_q;
endmodule

//--- logic/swe_wake_map.sv
// swe_wake_map: gates each wake source by status, enable and power context;
// assumes inputs are stable registered levels.
`timescale 1ns/1ps
module swe_wake_map
(
  // mapping side
  swe_wake_if.map_end wif
);
  // RQ24 per-state permitted sources
  assign wif.allowed = swe_pkg::allowed_mask(wif.ctx);
  assign wif.src_hit = wif.src_status & wif.src_enable & wif.allowed;
endmodule

//--- logic/swe_wake_ctrl.sv
// swe_wake_ctrl: suspend/wake control with wishbone registers;
// assumes one clock, usb link and mac events synchronous to clk.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// RQ1: suspend 0/1 take all but good-frame wakes; the code also leaves out the vbus source
// RQ2: suspend 2 takes only resume and pins
// RQ3: good-frame wake only in suspend 3
// RQ4: unpowered, pme and detach have fixed sources
// RQ5: pin wake sets its interrupt status flag
// RQ6: host clears pending status before suspending
// RQ7: wake sends resume or u0 plus notification
// RQ8: wake may release suspend indicator early
// RQ9: host enables remote wake features first
// RQ10: leave u1/u2/l1 without host help
// RQ11: software arms pin enable and polarity
// RQ12: pin wake returns normal, flags per pin
// RQ13: software follows lan wake arming order
// RQ14: address and broadcast wakes own enables
// RQ15: mac status wakes at once, holds
// RQ16: phy status wakes at once, holds
// RQ17: software follows link change arming order
// RQ18: good frame needs filter enable, lan off
// RQ19: store frames after good wake, keep bit
// RQ20: wake source register records the cause
// RQ21: mode 00 s0/1, 10 s2, 11 s3
// RQ22: bus reset or pin reset gives unconfigured
// RQ23: suspend only from normal, back on wake
// RQ24: wake is or of permitted enabled sources
// RQ25: status flags sticky until cleared and ended
module swe_wake_ctrl #(
  parameter int unsigned NUM_PINS = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // usb link
  input wire logic usb_bus_reset,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic usb_resume,
  input wire logic usb_superspeed,
  input wire logic dev_remote_wake_en,
  input wire logic func_remote_wake_en,
  input wire logic link_low_power,
  input wire logic link_tx_pending,
  output logic resume_signal,
  output logic u0_request,
  output logic func_wake_notify,
  output logic link_exit_req,
  output logic suspend_n,
  // power context
  input wire logic vbus_det,
  input wire logic unpowered,
  input wire logic pme_mode,
  input wire logic detach_mode,
  // mac and phy events
  input wire logic [7:0] mac_event,
  input wire logic mac_wake_active,
  input wire logic phy_irq,
  input wire logic rx_frame_done,
  input wire logic rx_frame_is_wake,
  output logic rx_store,
  // pins
  input wire logic [7:0] pin_level
);
  if (NUM_PINS != 8)
  begin : g_bad
    $error("swe_wake_ctrl serves exactly eight wake pins");
  end

  typedef enum logic [3:0] {
    SWE_UNCFG = 4'h1,
    SWE_NORMAL = 4'h2,
    SWE_SUSP = 4'h4,
    SWE_WAKE = 4'h8
  } swe_state_e;

  swe_state_e state;
  swe_state_e next_state;
  swe_wake_if wif ();

  logic [1:0] wake_pending_status;
  logic lan_en;
  logic phy_en;
  logic suspn_rel;
  logic [1:0] mode;
  logic [1:0] susp_mode;
  logic [8:0] w1_ctl;
  logic [7:0] mac_flag;
  logic [7:0] pin_en;
  logic [7:0] pin_pol;
  logic [7:0] pin_func;
  logic [7:0] pin_flag;
  logic [19:0] wake_src;
  logic susp_q;
  logic wake_req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] w1c;
  logic [31:0] rdata;

  // byte enables expand to a bit mask for every write
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  swe_pin_wake u_pin (
    .clk(clk),
    .rst(rst),
    .wif(wif.pin_end)
  );

  swe_wake_map u_map (
    .wif(wif.map_end)
  );

  // write takes effect at the edge where ack is seen high
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wmask = lane_mask(wb_sel_i);
  assign w1c = wb_dat_i & wmask;

  always_ff @(posedge clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      swe_pkg::OFF_PMC:
        rdata = {22'h0, mode, 1'b0, suspn_rel, phy_en, lan_en, 2'h0, wake_pending_status};
      swe_pkg::OFF_WCS1: rdata = {8'h0, mac_flag, 7'h0, w1_ctl};
      swe_pkg::OFF_PIN: rdata = {8'h0, pin_func, pin_pol, pin_en};
      swe_pkg::OFF_ISR: rdata = {24'h0, pin_flag};
      swe_pkg::OFF_SRC: rdata = {12'h0, wake_src};
      swe_pkg::OFF_STAT: rdata = {21'h0, state, wif.ctx};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
      wb_dat_o <= rdata;
  end

  // control fields; deconfiguring or bus reset returns mode to default
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
    begin
      lan_en <= 1'b0;
      phy_en <= 1'b0;
      suspn_rel <= 1'b0;
      mode <= swe_pkg::MODE_RESET;
      w1_ctl <= 9'h000;
      pin_en <= 8'h00;
      pin_pol <= 8'h00;
      pin_func <= 8'h00;
    end
    else if (!usb_configured)
      mode <= swe_pkg::MODE_RESET;
    else if (wr && wb_adr_i == swe_pkg::OFF_PMC)
    begin
      if (wb_sel_i[0])
      begin
        lan_en <= wb_dat_i[swe_pkg::PMC_LAN_EN];
        phy_en <= wb_dat_i[swe_pkg::PMC_PHY_EN];
        suspn_rel <= wb_dat_i[swe_pkg::PMC_SUSPN_REL];
      end
      if (wb_sel_i[1])
        mode <= wb_dat_i[swe_pkg::PMC_MODE_LSB +: 2];
    end
    else if (wr && wb_adr_i == swe_pkg::OFF_WCS1)
      w1_ctl <= (w1_ctl & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]);
    else if (wr && wb_adr_i == swe_pkg::OFF_PIN)
    begin
      pin_en <= wb_sel_i[0] ? wb_dat_i[7:0] : pin_en;
      pin_pol <= wb_sel_i[1] ? wb_dat_i[swe_pkg::PIN_POL_LSB +: 8] : pin_pol;
      pin_func <= wb_sel_i[2] ? wb_dat_i[swe_pkg::PIN_FUNC_LSB +: 8]
        : pin_func;
    end
  end

  // RQ16 phy status sticky while the phy interrupt stands
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      wake_pending_status[0] <= 1'b0;
    else if (phy_irq)
      wake_pending_status[0] <= 1'b1;
    else if (wr && wb_adr_i == swe_pkg::OFF_PMC && w1c[0])
      wake_pending_status[0] <= 1'b0;
  end

  // RQ15 enabled mac events set it; no clear while active
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      wake_pending_status[1] <= 1'b0;
    else if (|(mac_event & wif.src_enable[swe_pkg::S_MAC_LSB +: 8])
      || mac_wake_active)
      wake_pending_status[1] <= 1'b1;
    else if (wr && wb_adr_i == swe_pkg::OFF_PMC && w1c[1])
      wake_pending_status[1] <= 1'b0;
  end

  // RQ25 per-source mac flags, set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      mac_flag <= 8'h00;
    else if (wr && wb_adr_i == swe_pkg::OFF_WCS1)
      mac_flag <= (mac_flag & ~w1c[swe_pkg::W1_STAT_LSB +: 8]) | mac_event;
    else
      mac_flag <= mac_flag | mac_event;
  end

  // RQ5 pin event sets its interrupt status flag
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      pin_flag <= 8'h00;
    else if (wr && wb_adr_i == swe_pkg::OFF_ISR)
      pin_flag <= (pin_flag & ~w1c[7:0]) | wif.pin_event;
    else
      pin_flag <= pin_flag | wif.pin_event;
  end

  assign wif.pin_level = pin_level;
  assign wif.pin_en = pin_en;
  assign wif.pin_pol = pin_pol;
  assign wif.pin_func = pin_func;

  // RQ21 mode decode; unconfigured suspends only to state 2
  always_comb
  begin
    if (unpowered)
      wif.ctx = swe_pkg::SWE_CTX_UNPOW;
    else if (pme_mode)
      wif.ctx = swe_pkg::SWE_CTX_PME;
    else if (detach_mode)
      wif.ctx = swe_pkg::SWE_CTX_DETACH;
    else if (state != SWE_SUSP)
      wif.ctx = swe_pkg::SWE_CTX_NONE;
    else if (susp_mode == swe_pkg::MODE_S01)
      wif.ctx = swe_pkg::SWE_CTX_S01;
    else if (susp_mode == swe_pkg::MODE_S3)
      wif.ctx = swe_pkg::SWE_CTX_S3;
    else
      wif.ctx = swe_pkg::SWE_CTX_S2;
  end

  assign wif.src_status = {|pin_flag, wake_pending_status[0], mac_flag[7:1],
    mac_flag[0] | wake_pending_status[1], vbus_det, usb_resume};
  // RQ14 address and broadcast wakes gated by own enables
  // RQ18 good frame needs filter enable with lan enable low
  assign wif.src_enable = {1'b1, phy_en, w1_ctl[swe_pkg::W1_EETX_EN],
    w1_ctl[swe_pkg::W1_EERX_EN], lan_en,
    w1_ctl[swe_pkg::W1_FILT_EN] & ~lan_en,
    lan_en & w1_ctl[swe_pkg::W1_DA_EN],
    lan_en & w1_ctl[swe_pkg::W1_BROADCAST_WAKE_ENABLE], lan_en, lan_en, 1'b1, 1'b1};
  // RQ24 combined wake request
  assign wake_req = |wif.src_hit;

  // RQ23 suspend entry only from normal states
  always_comb
  begin
    next_state = state;
    case (state)
      SWE_UNCFG: next_state = usb_suspend ? SWE_SUSP
        : (usb_configured ? SWE_NORMAL : SWE_UNCFG);
      SWE_NORMAL: next_state = usb_suspend ? SWE_SUSP
        : (usb_configured ? SWE_NORMAL : SWE_UNCFG);
      SWE_SUSP: next_state = wake_req ? SWE_WAKE : SWE_SUSP;
      SWE_WAKE: next_state = usb_configured ? SWE_NORMAL : SWE_UNCFG;
      default: next_state = SWE_UNCFG;
    endcase
  end

  // RQ22 bus reset or reset pin gives unconfigured normal
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      state <= SWE_UNCFG;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      susp_mode <= swe_pkg::MODE_RESET;
    else if (state != SWE_SUSP && next_state == SWE_SUSP)
      susp_mode <= (state == SWE_UNCFG) ? swe_pkg::MODE_RESET : mode;
  end

  // RQ20 RQ12 record which sources ended the suspend
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      wake_src <= 20'h00000;
    else if (state == SWE_SUSP && wake_req)
      wake_src <= {1'b0, wif.src_hit[swe_pkg::S_LINK:swe_pkg::S_RES],
        pin_flag & {8{wif.src_hit[swe_pkg::S_GPIO]}}};
    else if (wr && wb_adr_i == swe_pkg::OFF_SRC)
      wake_src <= wake_src & ~w1c[19:0];
  end

  // RQ7 RQ9 remote wake per speed, only when host allowed it
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
    begin
      resume_signal <= 1'b0;
      u0_request <= 1'b0;
      func_wake_notify <= 1'b0;
    end
    else
    begin
      resume_signal <= state == SWE_SUSP && next_state == SWE_WAKE
        && !usb_resume && !usb_superspeed && dev_remote_wake_en;
      u0_request <= state == SWE_SUSP && next_state == SWE_WAKE
        && !usb_resume && usb_superspeed && func_remote_wake_en;
      func_wake_notify <= u0_request;
    end
  end

  // RQ8 suspend indicator, optionally released on wake detect
  always_ff @(posedge clk)
  begin
    if (rst | usb_bus_reset)
      suspend_n <= 1'b1;
    else if (next_state == SWE_SUSP)
      suspend_n <= 1'b0;
    else
      suspend_n <= next_state != SWE_WAKE || suspn_rel;
  end

  // RQ10 leave u1/u2/l1 on own traffic
  always_ff @(posedge clk)
  begin
    if (rst)
      link_exit_req <= 1'b0;
    else
      link_exit_req <= link_low_power & link_tx_pending;
  end

  // RQ19 keep trigger frame only if asked; later frames stored
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_store <= 1'b0;
    else
      rx_store <= rx_frame_done
        & (~rx_frame_is_wake | w1_ctl[swe_pkg::W1_KEEP]);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      susp_q <= 1'b0;
    else
      susp_q <= state == SWE_SUSP;
  end

  a_ack_single: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_ack_timely: assert property (@(posedge clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_s2_lan_off: assert property (@(posedge clk) disable iff (rst) // RQ2
    wif.ctx == swe_pkg::SWE_CTX_S2 |-> (wif.src_hit & 12'h7fe) == 12'h0)
    else $error("lan source woke suspend 2");
  a_good_s3_only: assert property (@(posedge clk) disable iff (rst) // RQ3
    wif.src_hit[swe_pkg::S_GOOD] |-> wif.ctx == swe_pkg::SWE_CTX_S3)
    else $error("good frame outside suspend 3");
  a_pin_flag_set: assert property (@(posedge clk) disable iff (rst) // RQ5
    wif.pin_event != 8'h00 && !usb_bus_reset
    |=> (pin_flag & $past(wif.pin_event)) == $past(wif.pin_event))
    else $error("pin flag not set");
  a_mac_hold: assert property (@(posedge clk) // RQ15
    disable iff (rst || usb_bus_reset)
    mac_wake_active |=> wake_pending_status[1]) else $error("mac status cleared");
  a_phy_hold: assert property (@(posedge clk) // RQ16
    disable iff (rst || usb_bus_reset)
    phy_irq |=> wake_pending_status[0]) else $error("phy status cleared");
  a_wake_seq: assert property (@(posedge clk) disable iff (rst) // RQ23
    state == SWE_SUSP && wake_req && !usb_bus_reset
    |=> state == SWE_WAKE ##1 (state == SWE_NORMAL || state == SWE_UNCFG))
    else $error("wake did not return to normal");
  a_reset_uncfg: assert property (@(posedge clk) // RQ22
    usb_bus_reset |=> state == SWE_UNCFG) else $error("bus reset missed");
  a_susp_entry: assert property (@(posedge clk) disable iff (rst) // RQ23
    state == SWE_SUSP && !susp_q
    |-> $past(state) == SWE_NORMAL || $past(state) == SWE_UNCFG)
    else $error("suspend from wrong state");
  a_ss_notify: assert property (@(posedge clk) // RQ7
    disable iff (rst || usb_bus_reset)
    u0_request |=> func_wake_notify) else $error("no function wake");
  a_wake_release: assert property (@(posedge clk) // RQ8
    disable iff (rst || usb_bus_reset)
    state == SWE_SUSP && wake_req |=> suspend_n == $past(suspn_rel))
    else $error("suspend indicator release wrong");
endmodule

//--- verif/swe_host_model.sv
// swe_host_model: usb host controller and driver facing the block
// assumes bench requests arrive as levels or pulses on clk.
`timescale 1ns/1ps
module swe_host_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench requests
  input wire logic sleep_req,
  input wire logic resume_req,
  input wire logic ss_mode,
  // device wake requests
  input wire logic resume_signal,
  input wire logic u0_request,
  // link state toward the device
  output logic usb_suspend,
  output logic usb_resume,
  output logic usb_superspeed,
  output logic dev_remote_wake_en,
  output logic func_remote_wake_en
);
  always_ff @(posedge clk)
  begin
    usb_superspeed <= ss_mode & ~rst;
    func_remote_wake_en <= ss_mode & ~rst;
    dev_remote_wake_en <= ~ss_mode & ~rst;
  end
  // suspend held until any wake ends it
  always_ff @(posedge clk)
  begin
    if (rst | resume_signal | u0_request | resume_req)
      usb_suspend <= 1'b0;
    else if (sleep_req)
      usb_suspend <= 1'b1;
    usb_resume <= resume_req & ~rst;
  end
endmodule

//--- verif/swe_wake_ctrl_tb.sv
// swe_wake_ctrl_tb: self-checking bench for the suspend/wake control
// assumes the host model ends the suspend on every remote wake.
`timescale 1ns/1ps
module swe_wake_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, usb_bus_reset = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, mac_event = 8'h00, pin_level = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, g;
  logic usb_configured = 1'b1, usb_suspend, usb_resume, usb_superspeed;
  logic dev_remote_wake_en, func_remote_wake_en, link_low_power = 1'b0;
  logic link_tx_pending = 1'b0, resume_signal, u0_request;
  logic func_wake_notify, link_exit_req, suspend_n, rx_store;
  logic vbus_det = 1'b0, unpowered = 1'b0, pme_mode = 1'b0;
  logic detach_mode = 1'b0, mac_wake_active = 1'b0, phy_irq = 1'b0;
  logic rx_frame_done = 1'b0, rx_frame_is_wake = 1'b0;
  logic sleep_req = 1'b0, resume_req = 1'b0, ss_mode = 1'b0, pol;
  int n_fail = 0, checks = 0, k, r;
  always #25 clk = ~clk;
  swe_wake_ctrl #(.NUM_PINS(8)) u_dut (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .usb_bus_reset(usb_bus_reset),
    .usb_configured(usb_configured), .usb_suspend(usb_suspend),
    .usb_resume(usb_resume), .usb_superspeed(usb_superspeed),
    .dev_remote_wake_en(dev_remote_wake_en),
    .func_remote_wake_en(func_remote_wake_en),
    .link_low_power(link_low_power), .link_tx_pending(link_tx_pending),
    .resume_signal(resume_signal), .u0_request(u0_request),
    .func_wake_notify(func_wake_notify), .link_exit_req(link_exit_req),
    .suspend_n(suspend_n), .vbus_det(vbus_det), .unpowered(unpowered),
    .pme_mode(pme_mode), .detach_mode(detach_mode), .mac_event(mac_event),
    .mac_wake_active(mac_wake_active), .phy_irq(phy_irq),
    .rx_frame_done(rx_frame_done), .rx_frame_is_wake(rx_frame_is_wake),
    .rx_store(rx_store), .pin_level(pin_level));
  swe_host_model u_host (.clk(clk), .rst(rst), .sleep_req(sleep_req),
    .resume_req(resume_req), .ss_mode(ss_mode),
    .resume_signal(resume_signal), .u0_request(u0_request),
    .usb_suspend(usb_suspend), .usb_resume(usb_resume),
    .usb_superspeed(usb_superspeed), .dev_remote_wake_en(dev_remote_wake_en),
    .func_remote_wake_en(func_remote_wake_en));

  function automatic logic [31:0] pmc(input logic lan, input logic phy,
    input logic [1:0] mode);
    pmc = 32'h0;
    pmc[swe_pkg::PMC_LAN_EN] = lan;
    pmc[swe_pkg::PMC_PHY_EN] = phy;
    pmc[swe_pkg::PMC_SUSPN_REL] = 1'b1;
    pmc[swe_pkg::PMC_MODE_LSB +: 2] = mode;
  endfunction
  function automatic logic [31:0] pin_word(input int p, input logic hi);
    pin_word = 32'h0;
    pin_word[p] = 1'b1;
    pin_word[swe_pkg::PIN_POL_LSB + p] = hi;
    pin_word[swe_pkg::PIN_FUNC_LSB + p] = 1'b1;
  endfunction
  // packs counts of resume, u0, notify-after-u0 and stored frames
  function automatic logic [31:0] evt(input int a, b, c, d);
    evt = {a[7:0], b[7:0], c[7:0], d[7:0]};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40)
      chk(32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task watch(input int n, output logic [31:0] got);
    int hs, ss, nt, st, at;
    {hs, ss, nt, st} = '0;
    at = -9;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (resume_signal === 1'b1) hs++;
      if (u0_request === 1'b1)
      begin
        ss++;
        at = i;
      end
      if (func_wake_notify === 1'b1 && at == i - 1) nt++;
      if (rx_store === 1'b1) st++;
    end
    got = evt(hs, ss, nt, st);
  endtask
  task sleep;
    int n;
    n = 0;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    while (suspend_n !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, suspend_n}, 32'h0);
  endtask
  task mac_pulse(input logic [7:0] v);
    mac_event <= v;
    @(posedge clk);
    mac_event <= 8'h00;
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    r = $urandom(32'h68ee);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(swe_pkg::OFF_PMC, 0, 0, q);
    chk(q & 32'h373, {22'h0, swe_pkg::MODE_RESET, 8'h0});
    wb(8'h18, 1, 32'hffffffff, q);
    wb(8'h18, 0, 0, q);
    chk(q, 32'h0);
    link_low_power <= 1'b1;
    link_tx_pending <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, link_exit_req}, 32'h1);
    link_tx_pending <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, link_exit_req}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      k = $urandom_range(7, 0);
      pol = 1'($urandom_range(1, 0));
      pin_level <= pol ? 8'h00 : 8'hff;
      wb(swe_pkg::OFF_PIN, 1, pin_word(k, pol), q);
      wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S2), q);
      sleep();
      pin_level <= pin_level ^ (8'($urandom) & ~(8'h1 << k));
      watch(12, g);
      chk(g, evt(0, 0, 0, 0));
      pin_level[k] <= pol;
      watch(12, g);
      chk(g, evt(1, 0, 0, 0));
      chk({31'h0, suspend_n}, 32'h1);
      wb(swe_pkg::OFF_ISR, 0, 0, q);
      chk(q & 32'hff, 32'h1 << k);
      wb(swe_pkg::OFF_SRC, 0, 0, q);
      chk(q & 32'hff, 32'h1 << k);
      wb(swe_pkg::OFF_ISR, 1, 32'hffffffff, q);
      wb(swe_pkg::OFF_SRC, 1, 32'hffffffff, q);
    end
    wb(swe_pkg::OFF_WCS1, 1, 32'h33, q);
    wb(swe_pkg::OFF_PMC, 1, pmc(1, 1, swe_pkg::MODE_S2), q);
    sleep();
    phy_irq <= 1'b1;
    mac_pulse(8'hef);
    watch(12, g);
    chk(g, evt(0, 0, 0, 0));
    resume_req <= 1'b1;
    watch(8, g);
    chk(g, evt(0, 0, 0, 0));
    chk({31'h0, suspend_n}, 32'h1);
    resume_req <= 1'b0;
    phy_irq <= 1'b0;
    // unpowered ignores pending status, vbus wakes
    sleep();
    unpowered <= 1'b1;
    watch(6, g);
    chk(g, evt(0, 0, 0, 0));
    vbus_det <= 1'b1;
    watch(6, g);
    chk(g, evt(1, 0, 0, 0));
    {unpowered, vbus_det} <= 2'b00;
    wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S2) | 32'h3, q);
    wb(swe_pkg::OFF_WCS1, 1, 32'hff0000, q);
    wb(swe_pkg::OFF_SRC, 1, 32'hffffffff, q);
    ss_mode <= 1'b1;
    // lan wake armed after status clear
    wb(swe_pkg::OFF_WCS1, 1, 32'h4, q);
    wb(swe_pkg::OFF_PMC, 1, pmc(1, 0, swe_pkg::MODE_S01), q);
    sleep();
    mac_pulse(8'h18);
    watch(12, g);
    chk(g, evt(0, 0, 0, 0));
    mac_pulse(8'h01);
    watch(12, g);
    chk(g, evt(0, 1, 1, 0));
    wb(swe_pkg::OFF_SRC, 0, 0, q);
    chk(q & 32'h400, 32'h400);
    wb(swe_pkg::OFF_SRC, 1, 32'hffffffff, q);
    wb(swe_pkg::OFF_WCS1, 1, 32'hff0000, q);
    ss_mode <= 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      {mac_wake_active, phy_irq} <= 2'b01 << b;
      repeat (2) @(posedge clk);
      wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S01) | 32'h3, q);
      wb(swe_pkg::OFF_PMC, 0, 0, q);
      chk(q & 32'h3, 32'h1 << b);
      {mac_wake_active, phy_irq} <= 2'b00;
      wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S01) | 32'h3, q);
      wb(swe_pkg::OFF_PMC, 0, 0, q);
      chk(q & 32'h3, 32'h0);
    end
    phy_irq <= 1'b1;
    @(posedge clk);
    phy_irq <= 1'b0;
    // phy wake armed, stale status left set
    wb(swe_pkg::OFF_PMC, 1, pmc(0, 1, swe_pkg::MODE_S01), q);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    watch(12, g);
    chk(g, evt(1, 0, 0, 0));
    wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S3) | 32'h3, q);
    wb(swe_pkg::OFF_SRC, 1, 32'hffffffff, q);
    // filter pass wake with lan off
    wb(swe_pkg::OFF_WCS1, 1, 32'h4, q);
    sleep();
    rx_frame_done <= 1'b1;
    rx_frame_is_wake <= 1'b1;
    mac_pulse(8'h10);
    rx_frame_done <= 1'b0;
    rx_frame_is_wake <= 1'b0;
    watch(12, g);
    chk(g, evt(1, 0, 0, 0));
    rx_frame_done <= 1'b1;
    @(posedge clk);
    rx_frame_done <= 1'b0;
    watch(4, g);
    chk(g, evt(0, 0, 0, 1));
    usb_bus_reset <= 1'b1;
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    wb(swe_pkg::OFF_PMC, 0, 0, q);
    chk(q & 32'h373, 32'h200);
    wb(swe_pkg::OFF_PMC, 1, pmc(0, 0, swe_pkg::MODE_S3), q);
    usb_configured <= 1'b0;
    repeat (2) @(posedge clk);
    wb(swe_pkg::OFF_PMC, 0, 0, q);
    chk(q & 32'h300, 32'h200);
    print_verdict();
  end
endmodule
